// ==== verilog/sfc_top.sv ====
// serial slave frame checker: receive fifo plus frame engine with echo and
// read responses, a small word store, lrc and crc checking
// assumes characters arrive already deserialised, on i_clock
// Notes on behaviour
// [RQ1] ascii frames carry two-char lrc, checked
// [RQ2] lrc sums address through data, modulo 256
// [RQ3] lrc sent is two's complement of sum
// [RQ4] rtu frames carry crc, checked on receive
// [RQ5] crc accumulator starts at all ones
// [RQ6] each byte xored into accumulator low bits
// [RQ7] shift right, xor polynomial if one out
// [RQ8] eight shift steps for every byte
// [RQ9] crc covers address through last data byte
// [RQ10] crc low byte sent before high byte
// [RQ11] ascii frames end with cr then lf
// [RQ12] rtu frame ends after four character silence
// [RQ13] write request: address then value, msb first
// [RQ14] write answered by exact echo of request
// [RQ15] read request: start and count, msb first
// [RQ16] read reply: count doubled, words ascending
// [RQ17] station addresses valid from 1 to 254
// [RQ18] host asks at most twenty words
// [RQ19] station zero is broadcast, never answered
// [RQ20] rtu frame needs four character silence first
// [RQ21] bad check or foreign address: drop silently
`timescale 1ns/1ps
`default_nettype none

module sfc_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clock,
  input  wire logic             i_nrst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [CW-1:0]               cnt;
    logic                        full;
    logic                        empty;
  } sfc_fifo_st_t;

  sfc_fifo_st_t r, n;
  logic         push, pop;

  always_comb begin
    n    = r;
    push = i_in_valid && !r.full;
    pop  = i_out_ready && !r.empty;
    if (push) begin
      n.mem[r.wp] = i_in_data;
      n.wp = (r.wp == PTR_LAST) ? '0 : r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = (r.rp == PTR_LAST) ? '0 : r.rp + 1'b1;
    end
    if (push && !pop) begin
      n.cnt = r.cnt + 1'b1;
    end else if (pop && !push) begin
      n.cnt = r.cnt - 1'b1;
    end
    n.full  = (n.cnt == CNT_FULL);
    n.empty = (n.cnt == '0);
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      r <= '{mem: '0, wp: '0, rp: '0, cnt: '0, full: 1'b0, empty: 1'b1};
    end else begin
      r <= n;
    end
  end

  assign o_in_ready  = !r.full;
  assign o_out_valid = !r.empty;
  assign o_out_data  = r.mem[r.rp];
endmodule : sfc_fifo

module sfc_top
  import sfc_pkg::*;
#(
  parameter int SILENCE = sfc_pkg::SILENCE_CYCLES
) (
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  input  wire logic        i_ascii_mode,
  input  wire logic [7:0]  i_station_addr,
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_data,
  output logic             o_rx_ready,
  output logic             o_tx_valid,
  output logic [7:0]       o_tx_data,
  input  wire logic        i_tx_ready,
  output logic             o_wr_strobe,
  output sfc_pkg::sfc_wr_t o_wr,
  output logic             o_frame_ok,
  output logic             o_frame_drop
);
  import sfc_pkg::*;

  localparam logic [GAP_W-1:0] SIL_LAST = GAP_W'(SILENCE - 1);

  sfc_state_t r, n;
  sfc_rx_t    push_d, pop_d;
  logic       push_v, fifo_rdy, pop_v, take, load, done, good, bcast;
  logic [7:0] fn;

  // frame-accumulation counters, flags and checks back to their start values; buf_b and nib are kept
  function automatic sfc_state_t frame_clear(input sfc_state_t s);
    sfc_state_t t;
    t        = s;
    t.len    = 4'h0;
    t.bad    = 1'b0;
    t.act    = 1'b0;
    t.got_cr = 1'b0;
    t.nhalf  = 1'b0;
    t.crc    = CRC_SEED; // RQ5
    t.sum    = ZERO_BYTE;
    return t;
  endfunction : frame_clear

  function automatic sfc_state_t add_byte(input sfc_state_t s,
                                          input logic [7:0] b);
    sfc_state_t t;
    t = s;
    if (s.len < 4'(BUF_BYTES)) begin
      t.buf_b[s.len[2:0]] = b;
      t.len = s.len + 1'b1;
    end else begin
      t.bad = 1'b1;
    end
    t.crc = sfc_crc_byte(s.crc, b); // RQ6 RQ7 RQ8 RQ9
    t.sum = s.sum + b; // RQ2
    return t;
  endfunction : add_byte

  sfc_fifo #(
    .WIDTH ($bits(sfc_rx_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_rx_fifo (
    .i_clock     (i_clock),
    .i_nrst      (i_nrst),
    .i_in_valid  (push_v),
    .o_in_ready  (fifo_rdy),
    .i_in_data   (push_d),
    .o_out_valid (pop_v),
    .i_out_ready (r.st == ST_RECV),
    .o_out_data  (pop_d)
  );

  always_comb begin
    logic [4:0]        hv;
    logic [7:0]        c, rb;
    logic [5:0]        wi;
    logic [WIDX_W-1:0] wa;
    logic [7:0]        lrc;
    logic              own_ok, chk_ok, fn_ok, adr_ok;
    hv = 5'h00;
    c  = pop_d.data;
    rb = ZERO_BYTE;
    wi = 6'h00;
    wa = '0;
    lrc = ZERO_BYTE;
    own_ok = 1'b0;
    chk_ok = 1'b0;
    fn_ok  = 1'b0;
    adr_ok = 1'b0;
    n  = r;
    n.wr_stb   = 1'b0;
    n.ok_stb   = 1'b0;
    n.drop_stb = 1'b0;
    push_v = 1'b0;
    push_d = '0;
    done   = 1'b0;

    // line front: silence timing ahead of the fifo
    if (i_rx_valid) begin
      n.gap   = '0;
      n.quiet = 1'b0;
      if (!i_ascii_mode && !r.in_frame) begin
        n.in_frame = 1'b1;
        n.fbad     = !r.quiet; // RQ20
      end
      push_v = 1'b1;
      push_d = '{marker: 1'b0, bad: 1'b0, data: i_rx_data};
      // overrun marks an rtu frame bad instead of stalling the line; in ascii mode the character is only lost
      if (!fifo_rdy) begin
        n.fbad = 1'b1;
      end
    end else begin
      if (!r.quiet) begin
        if (r.gap == SIL_LAST) begin
          n.quiet = 1'b1;
        end else begin
          n.gap = r.gap + 1'b1;
        end
      end
      if (r.quiet && r.in_frame && !i_ascii_mode) begin
        push_v = 1'b1; // RQ12
        push_d = '{marker: 1'b1, bad: r.fbad, data: ZERO_BYTE};
        if (fifo_rdy) begin
          n.in_frame = 1'b0;
        end
      end
    end

    // frame assembly
    take = pop_v && (r.st == ST_RECV);
    if (take && !i_ascii_mode) begin
      if (pop_d.marker) begin
        done  = 1'b1;
        n.bad = r.bad || pop_d.bad;
      end else begin
        n = add_byte(n, c);
      end
    end else if (take) begin
      hv = sfc_hex_val(c);
      if (c == CHR_SOF) begin
        n     = frame_clear(n);
        n.act = 1'b1;
      end else if (r.act) begin
        if (r.got_cr) begin
          done  = 1'b1; // RQ11
          n.bad = r.bad || (c != CHR_LF);
        end else if (c == CHR_CR) begin
          n.got_cr = 1'b1;
        end else if (hv[4] && r.nhalf) begin
          n       = add_byte(n, {r.nib, hv[3:0]});
          n.nhalf = 1'b0;
        end else if (hv[4]) begin
          n.nib   = hv[3:0];
          n.nhalf = 1'b1;
        end else begin
          n.bad = 1'b1;
        end
      end
    end

    // frame judgement
    fn     = n.buf_b[BI_FN];
    bcast  = (n.buf_b[BI_ADDR] == ADDR_BCAST); // RQ19
    own_ok = (i_station_addr >= ADDR_MIN) && (i_station_addr <= ADDR_MAX); // RQ17
    adr_ok = bcast || (n.buf_b[BI_ADDR] == i_station_addr); // RQ21
    if (i_ascii_mode) begin
      chk_ok = (n.sum == ZERO_BYTE) && (n.len == LEN_ASCII) && !n.nhalf; // RQ1
    end else begin
      chk_ok = (n.crc == CRC_RESIDUE) && (n.len == LEN_RTU); // RQ4
    end
    // reads above twenty words are dropped rather than answered
    fn_ok = (fn == FN_WRITE) ||
            ((fn == FN_READ) && (n.buf_b[BI_V_HI] == ZERO_BYTE) &&
             (n.buf_b[BI_V_LO] >= ADDR_MIN) &&
             (n.buf_b[BI_V_LO] <= MAX_WORDS)); // RQ15
    good = done && !n.bad && own_ok && adr_ok && chk_ok && fn_ok;

    if (done) begin
      n = frame_clear(n);
      if (!good) begin
        n.drop_stb = 1'b1; // RQ21
      end else begin
        n.ok_stb = 1'b1;
        if (fn == FN_WRITE) begin
          // word store decodes only the low address bits
          n.wr_stb  = 1'b1; // RQ13
          n.wr.addr = {n.buf_b[BI_RA_HI], n.buf_b[BI_RA_LO]};
          n.wr.data = {n.buf_b[BI_V_HI], n.buf_b[BI_V_LO]};
          n.mem[n.buf_b[BI_RA_LO][WIDX_W-1:0]] = n.wr.data;
        end
        if (!bcast) begin
          n.st   = i_ascii_mode ? ST_SOF : ST_BODY;
          n.idx  = 6'h00;
          n.cph  = 1'b0;
          n.tcrc = CRC_SEED;
          n.tsum = ZERO_BYTE;
          n.rlen = (fn == FN_WRITE) ? WR_LEN :
                   RD_HDR + {n.buf_b[BI_V_LO][4:0], 1'b0};
        end
      end
    end

    // response byte at the send index
    wi = (r.idx - RD_HDR) >> 1;
    wa = r.buf_b[BI_RA_LO][WIDX_W-1:0] + wi[WIDX_W-1:0];
    if (r.buf_b[BI_FN] == FN_WRITE) begin
      rb = r.buf_b[r.idx[2:0]]; // RQ14
    end else if (r.idx == IDX_ADDR) begin
      rb = r.buf_b[BI_ADDR];
    end else if (r.idx == IDX_FN) begin
      rb = FN_READ;
    end else if (r.idx == IDX_CNT) begin
      rb = {r.buf_b[BI_V_LO][6:0], 1'b0}; // RQ16
    end else if (r.idx[0] ^ RD_HDR[0]) begin
      // odd offset past the header is the low byte of the word
      rb = r.mem[wa][7:0];
    end else begin
      rb = r.mem[wa][15:8]; // RQ16
    end
    lrc = ZERO_BYTE - r.tsum; // RQ3

    // transmit sequencer, one character per free output slot
    load = !r.tx_valid || i_tx_ready;
    if (load) begin
      n.tx_valid = 1'b0;
      case (r.st)
        // idle: keep any reply that the judgement above has just started
        ST_RECV: begin
          n.tx_valid = 1'b0;
        end
        ST_SOF: begin
          n.tx_valid = 1'b1;
          n.tx_data  = CHR_SOF;
          n.st       = ST_BODY;
        end
        ST_BODY: begin
          n.tx_valid = 1'b1;
          if (i_ascii_mode && !r.cph) begin
            n.tx_data = sfc_hex_chr(rb[7:4]);
            n.cph     = 1'b1;
          end else begin
            n.tx_data = i_ascii_mode ? sfc_hex_chr(rb[3:0]) : rb;
            n.cph     = 1'b0;
            n.tcrc    = sfc_crc_byte(r.tcrc, rb); // RQ9
            n.tsum    = r.tsum + rb; // RQ2
            n.idx     = r.idx + 1'b1;
            if (n.idx == r.rlen) begin
              n.st = ST_CHK;
            end
          end
        end
        ST_CHK: begin
          n.tx_valid = 1'b1;
          n.cph      = !r.cph;
          if (i_ascii_mode) begin
            n.tx_data = sfc_hex_chr(r.cph ? lrc[3:0] : lrc[7:4]); // RQ1
            n.st      = r.cph ? ST_CR : ST_CHK;
          end else begin
            n.tx_data = r.cph ? r.tcrc[15:8] : r.tcrc[7:0]; // RQ10
            n.st      = r.cph ? ST_RECV : ST_CHK;
          end
        end
        ST_CR: begin
          n.tx_valid = 1'b1;
          n.tx_data  = CHR_CR; // RQ11
          n.st       = ST_LF;
        end
        ST_LF: begin
          n.tx_valid = 1'b1;
          n.tx_data  = CHR_LF;
          n.st       = ST_RECV;
        end
        default: begin
          n.st = ST_RECV;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      r       <= '0;
      r.st    <= ST_RECV;
      r.crc   <= CRC_SEED;
      r.tcrc  <= CRC_SEED;
    end else begin
      r <= n;
    end
  end

  assign o_rx_ready   = fifo_rdy;
  assign o_tx_valid   = r.tx_valid;
  assign o_tx_data    = r.tx_data;
  assign o_wr_strobe  = r.wr_stb;
  assign o_wr         = r.wr;
  assign o_frame_ok   = r.ok_stb;
  assign o_frame_drop = r.drop_stb;

  a_crc_seed: assert property (@(posedge i_clock) disable iff (!i_nrst) // RQ5
    done |=> (r.crc == CRC_SEED) && (r.sum == ZERO_BYTE))
    else $error("accumulators not reseeded after frame");

  a_bcast_quiet: assert property (@(posedge i_clock) disable iff (!i_nrst) // RQ19
    (done && good && bcast) |=> (r.st == ST_RECV) [*2])
    else $error("broadcast frame started a reply");

  a_bad_drop: assert property (@(posedge i_clock) disable iff (!i_nrst) // RQ21
    (done && !good) |=> (r.st == ST_RECV) && !o_wr_strobe && o_frame_drop)
    else $error("rejected frame was acted upon");

  a_write_apply: assert property (@(posedge i_clock) disable iff (!i_nrst) // RQ13
    (done && good && fn == FN_WRITE) |=> o_wr_strobe &&
      (o_wr.addr == {$past(r.buf_b[BI_RA_HI]), $past(r.buf_b[BI_RA_LO])}) &&
      (o_wr.data == {$past(r.buf_b[BI_V_HI]), $past(r.buf_b[BI_V_LO])}))
    else $error("write frame not applied with its fields");

  a_crc_low_first: assert property (@(posedge i_clock) disable iff (!i_nrst) // RQ10
    (r.st == ST_CHK && !i_ascii_mode && load && !r.cph) |=>
      o_tx_valid && (o_tx_data == $past(r.tcrc[7:0])) && (r.st == ST_CHK))
    else $error("crc low byte not sent first");

  a_cr_then_lf: assert property (@(posedge i_clock) disable iff (!i_nrst) // RQ11
    (r.st == ST_CR && load) |=> (o_tx_data == CHR_CR) && (r.st == ST_LF))
    else $error("frame end characters out of order");

  a_silence_end: assert property (@(posedge i_clock) disable iff (!i_nrst) // RQ12
    (r.quiet && r.in_frame && !i_rx_valid && !i_ascii_mode && fifo_rdy) |=>
      !r.in_frame)
    else $error("silence did not close the frame");

  a_read_count: assert property (@(posedge i_clock) disable iff (!i_nrst) // RQ16
    (r.st == ST_BODY && load && !i_ascii_mode && r.buf_b[BI_FN] == FN_READ &&
     r.idx == IDX_CNT) |=>
      o_tx_data == {$past(r.buf_b[BI_V_LO][6:0]), 1'b0})
    else $error("byte count is not twice the word count");

  a_lrc_value: assert property (@(posedge i_clock) disable iff (!i_nrst) // RQ3
    (r.st == ST_CHK && i_ascii_mode && load && !r.cph) |=>
      o_tx_data == sfc_hex_chr(4'((ZERO_BYTE - $past(r.tsum)) >> 4)))
    else $error("lrc high digit is not the complemented sum");

  a_tx_hold: assert property (@(posedge i_clock) disable iff (!i_nrst) // RQ14
    (o_tx_valid && !i_tx_ready) |=> o_tx_valid && $stable(o_tx_data))
    else $error("reply character changed while stalled");
endmodule : sfc_top

`default_nettype wire

// ==== verilog/sfc_pkg.sv ====
// constants, types and helper functions of the serial slave frame checker
// assumes a byte-wide character source (uart) on the same clock
package sfc_pkg;

  localparam logic [7:0]  CHR_SOF     = 8'h3A;
  localparam logic [7:0]  CHR_CR      = 8'h0D;
  localparam logic [7:0]  CHR_LF      = 8'h0A;
  localparam logic [7:0]  CHR_0       = 8'h30;
  localparam logic [7:0]  CHR_9       = 8'h39;
  localparam logic [7:0]  CHR_A       = 8'h41;
  localparam logic [7:0]  CHR_F       = 8'h46;
  localparam logic [7:0]  HEX_ALPHA   = 8'h37;
  localparam logic [3:0]  HEX_TEN     = 4'hA;

  localparam logic [7:0]  FN_READ     = 8'h03;
  localparam logic [7:0]  FN_WRITE    = 8'h06;
  localparam logic [7:0]  ADDR_BCAST  = 8'h00;
  localparam logic [7:0]  ADDR_MIN    = 8'h01;
  localparam logic [7:0]  ADDR_MAX    = 8'hFE;
  localparam logic [7:0]  MAX_WORDS   = 8'h14;
  localparam logic [7:0]  ZERO_BYTE   = 8'h00;

  localparam logic [15:0] CRC_SEED    = 16'hFFFF;
  localparam logic [15:0] CRC_POLY    = 16'hA001;
  localparam logic [15:0] CRC_RESIDUE = 16'h0000;
  localparam int          CRC_STEPS   = 8;

  localparam int          BUF_BYTES   = 8;
  localparam int          BI_ADDR     = 0;
  localparam int          BI_FN       = 1;
  localparam int          BI_RA_HI    = 2;
  localparam int          BI_RA_LO    = 3;
  localparam int          BI_V_HI     = 4;
  localparam int          BI_V_LO     = 5;
  localparam logic [3:0]  LEN_RTU     = 4'h8;
  localparam logic [3:0]  LEN_ASCII   = 4'h7;
  localparam logic [5:0]  RD_HDR      = 6'h03;
  localparam logic [5:0]  WR_LEN      = 6'h06;
  localparam logic [5:0]  IDX_CNT     = 6'h02;
  localparam logic [5:0]  IDX_FN      = 6'h01;
  localparam logic [5:0]  IDX_ADDR    = 6'h00;

  localparam int          WORD_DEPTH  = 32;
  localparam int          WIDX_W      = 5;
  localparam int          FIFO_DEPTH  = 8;

  // line timing: silence of four character times of eleven bits
  localparam int          CLK_HZ        = 40_000_000;
  localparam int          BAUD          = 9600;
  localparam int          CHAR_BITS     = 11;
  localparam int          SILENCE_CHARS = 4;
  localparam int          SILENCE_CYCLES =
    (CLK_HZ * CHAR_BITS * SILENCE_CHARS + BAUD - 1) / BAUD;
  localparam int          GAP_W         = 20;

  typedef enum logic [5:0] {
    ST_RECV = 6'b000001,
    ST_SOF  = 6'b000010,
    ST_BODY = 6'b000100,
    ST_CHK  = 6'b001000,
    ST_CR   = 6'b010000,
    ST_LF   = 6'b100000
  } sfc_state_e_t;

  typedef struct packed {
    logic       marker;
    logic       bad;
    logic [7:0] data;
  } sfc_rx_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] data;
  } sfc_wr_t;

  typedef struct packed {
    sfc_state_e_t                   st;
    logic [GAP_W-1:0]               gap;
    logic                           quiet;
    logic                           in_frame;
    logic                           fbad;
    logic [BUF_BYTES-1:0][7:0]      buf_b;
    logic [3:0]                     len;
    logic                           bad;
    logic                           act;
    logic                           got_cr;
    logic                           nhalf;
    logic [3:0]                     nib;
    logic [15:0]                    crc;
    logic [7:0]                     sum;
    logic [WORD_DEPTH-1:0][15:0]    mem;
    logic [5:0]                     idx;
    logic [5:0]                     rlen;
    logic                           cph;
    logic [15:0]                    tcrc;
    logic [7:0]                     tsum;
    logic                           tx_valid;
    logic [7:0]                     tx_data;
    logic                           wr_stb;
    sfc_wr_t                        wr;
    logic                           ok_stb;
    logic                           drop_stb;
  } sfc_state_t;

  // eight shift steps per byte, reflected polynomial
  function automatic logic [15:0] sfc_crc_byte(input logic [15:0] c,
                                               input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < CRC_STEPS; i++) begin
      if (r[0]) begin
        r = (r >> 1) ^ CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction : sfc_crc_byte

  // bit 4 flags a valid upper-case hex digit
  function automatic logic [4:0] sfc_hex_val(input logic [7:0] c);
    logic [7:0] d;
    d = 8'h00;
    if (c >= CHR_0 && c <= CHR_9) begin
      d = c - CHR_0;
      return {1'b1, d[3:0]};
    end else if (c >= CHR_A && c <= CHR_F) begin
      d = c - HEX_ALPHA;
      return {1'b1, d[3:0]};
    end
    return 5'h00;
  endfunction : sfc_hex_val

  function automatic logic [7:0] sfc_hex_chr(input logic [3:0] n);
    if (n < HEX_TEN) begin
      return CHR_0 + {4'h0, n};
    end
    return HEX_ALPHA + {4'h0, n};
  endfunction : sfc_hex_chr

endpackage : sfc_pkg

// ==== dv/sfc_host.sv ====
// host model: sends request characters, collects reply characters
// assumes one clock shared with the frame checker
`timescale 1ns/1ps
`default_nettype none

module sfc_host (
  input  wire logic       i_clock,
  input  wire logic       i_rx_ready,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  output logic            o_tx_ready
);
  logic [7:0] got[$];
  logic       slow;

  initial begin
    o_rx_valid = 1'b0;
    o_rx_data  = 8'hA5;
    o_tx_ready = 1'b0;
    slow       = 1'b0;
  end

  // a slow host takes a reply character only every other cycle
  always @(posedge i_clock) begin
    if (i_tx_valid === 1'b1 && o_tx_ready === 1'b1) begin
      got.push_back(i_tx_data);
    end
    #1 o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
  end

  // called just after an edge; frame bytes come from the bench in order
  task automatic send_frame(input logic [7:0] q[$], input int gap);
    repeat (gap) @(posedge i_clock);
    #1;
    foreach (q[i]) begin
      while (i_rx_ready !== 1'b1) begin
        o_rx_valid = 1'b0;
        @(posedge i_clock);
        #1;
      end
      o_rx_data  = q[i];
      o_rx_valid = 1'b1;
      @(posedge i_clock);
      #1;
    end
    o_rx_valid = 1'b0;
    // stale data is inverted so it never repeats the last character
    o_rx_data  = ~o_rx_data;
  endtask : send_frame
endmodule : sfc_host

`default_nettype wire

// ==== dv/tb_top.sv ====
// self-checking bench for the frame checker, rtu and ascii framing
// assumes sfc_pkg, sfc_top and the host model are compiled first
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import sfc_pkg::*;
  localparam int SIL = 20;
  typedef logic [7:0] bq_t[$];
  logic       clk;
  logic       nrst;
  logic       ascii;
  logic [7:0] station;
  logic       rx_valid;
  logic [7:0] rx_data;
  logic       rx_ready;
  logic       tx_valid;
  logic [7:0] tx_data;
  logic       tx_ready;
  logic       wr_stb;
  sfc_wr_t    wr;
  logic       ok;
  logic       drop;
  int         failures;
  int         cmp_count;
  int         ok_n;
  int         drop_n;
  int         wr_n;
  bq_t        none;

  sfc_top #(.SILENCE(SIL)) dut (
    .i_clock(clk), .i_nrst(nrst), .i_ascii_mode(ascii),
    .i_station_addr(station), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
    .o_rx_ready(rx_ready), .o_tx_valid(tx_valid), .o_tx_data(tx_data),
    .i_tx_ready(tx_ready), .o_wr_strobe(wr_stb), .o_wr(wr),
    .o_frame_ok(ok), .o_frame_drop(drop));

  sfc_host host (
    .i_clock(clk), .i_rx_ready(rx_ready), .i_tx_valid(tx_valid),
    .i_tx_data(tx_data), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
    .o_tx_ready(tx_ready));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (ok === 1'b1) ok_n++;
    if (drop === 1'b1) drop_n++;
    if (wr_stb === 1'b1) wr_n++;
  end

  function automatic bq_t rtu(bq_t b);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return {b, c[7:0], c[15:8]};
  endfunction : rtu

  function automatic logic [7:0] hx(logic [3:0] n);
    return (n < 4'hA) ? 8'h30 + n : 8'h37 + n;
  endfunction : hx

  function automatic bq_t asc(bq_t b);
    bq_t        r;
    logic [7:0] s;
    r = {8'h3A};
    s = 8'h00;
    foreach (b[i]) s += b[i];
    b.push_back(-s);
    foreach (b[i]) r = {r, hx(b[i][7:4]), hx(b[i][3:0])};
    return {r, 8'h0D, 8'h0A};
  endfunction : asc

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic run(string nm, bq_t req, bq_t exp, bit e_ok, int gap);
    int n;
    ok_n = 0;
    drop_n = 0;
    host.got.delete();
    host.send_frame(req, gap);
    n = 0;
    while ((ok_n + drop_n == 0 || host.got.size() < exp.size()) && n < 400) begin
      @(posedge clk);
      n++;
    end
    // extra cycles so a stray reply character would still be caught
    repeat (10) @(posedge clk);
    #1;
    chk({nm, " ok"}, {31'b0, e_ok}, ok_n);
    chk({nm, " drop"}, {31'b0, !e_ok}, drop_n);
    chk({nm, " reply len"}, exp.size(), host.got.size());
    chk({nm, " in time"}, 1, n < 400);
    foreach (exp[i]) chk({nm, " reply"}, exp[i], host.got[i]);
  endtask : run

  task automatic t_rtu();
    bq_t w;
    bq_t f[4];
    w = '{8'h01, 8'h06, 8'h02, 8'h00, 8'h00, 8'h64, 8'h89, 8'h99};
    run("rtu first", w, none, 0, 0);
    run("rtu write", w, w, 1, SIL + 2);
    chk("write strobe", 1, wr_n);
    chk("write data", 32'h02000064, wr);
    run("two frames", {w, w}, none, 0, SIL + 2);
    run("bcast", rtu('{8'h00, 8'h06, 8'h02, 8'h01, 8'h12, 8'h34}), none, 1,
        SIL + 2);
    chk("bcast write", 32'h02011234, wr);
    host.slow = 1'b1;
    run("rtu read", '{8'h01, 8'h03, 8'h02, 8'h00, 8'h00, 8'h02, 8'hC5, 8'hB3},
        rtu('{8'h01, 8'h03, 8'h04, 8'h00, 8'h64, 8'h12, 8'h34}), 1,
        SIL + 2);
    host.slow = 1'b0;
    wr_n = 0;
    f[0] = w;
    f[0][7] = 8'h98;
    f[1] = rtu('{8'h02, 8'h06, 8'h02, 8'h00, 8'h00, 8'h01});
    f[2] = rtu('{8'h01, 8'h03, 8'h02, 8'h00, 8'h00, 8'h15});
    f[3] = rtu('{8'h01, 8'h05, 8'h02, 8'h00, 8'h00, 8'h01});
    foreach (f[i]) run("reject", f[i], none, 0, SIL + 2);
    station = 8'hFF;
    run("own addr out of range",
        rtu('{8'hFF, 8'h06, 8'h02, 8'h00, 8'h00, 8'h01}), none, 0,
        SIL + 2);
    station = 8'h01;
    chk("no write", 0, wr_n);
    $display("test rtu done");
  endtask : t_rtu

  task automatic t_ascii();
    bq_t a;
    ascii = 1'b1;
    a = asc('{8'h01, 8'h06, 8'h02, 8'h00, 8'h00, 8'h44});
    run("ascii write", a, a, 1, 2);
    chk("ascii data", 32'h02000044, wr);
    run("ascii read", asc('{8'h01, 8'h03, 8'h02, 8'h01, 8'h00, 8'h01}),
        asc('{8'h01, 8'h03, 8'h02, 8'h12, 8'h34}), 1, 2);
    a[13] = 8'h41;
    run("ascii bad lrc", a, none, 0, 2);
    a = asc('{8'h01, 8'h06, 8'h02, 8'h00, 8'h00, 8'h44});
    a[16] = 8'h0D;
    run("ascii no lf", a, none, 0, 2);
    ascii = 1'b0;
    $display("test ascii done");
  endtask : t_ascii

  task automatic test_done();
    $display("checks %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    test_done();
  end

  initial begin
    failures = 0;
    cmp_count = 0;
    ascii = 1'b0;
    station = 8'h01;
    nrst = 1'b0;
    repeat (2) @(posedge clk);
    #1 nrst = 1'b1;
    t_rtu();
    t_ascii();
    test_done();
  end
endmodule : tb_top

`default_nettype wire
